// *** rtl/qsce_pkg.sv ***
package qsce_pkg;
    // Host register select codes
    localparam logic [2:0] SEL_MODE = 3'h0;
    localparam logic [2:0] SEL_DELAY = 3'h1;
    localparam logic [2:0] SEL_QPTR = 3'h2;
    localparam logic [2:0] SEL_INTR = 3'h3;
    localparam logic [2:0] SEL_IPTR = 3'h4;
    localparam logic [2:0] SEL_DATA = 3'h5;
    // Indirect pointer section bases and width
    localparam int PTR_W = 6;
    localparam logic [5:0] BASE_TX = 6'h00;
    localparam logic [5:0] BASE_RX = 6'h10;
    localparam logic [5:0] BASE_CMD = 6'h20;
    localparam int ENTRIES = 16;
    // Command entry fields (position in the 16-bit data port word)
    localparam int CMD_HOLD = 15;
    localparam int CMD_WIDTH = 14;
    localparam int CMD_POST = 13;
    localparam int CMD_LEAD = 12;
    localparam int CMD_CS_LO = 8;
    // Mode register fields
    localparam int MODE_BITS_LO = 10;
    localparam int MODE_BAUD_LO = 0;
    // Delay register fields
    localparam int DLY_RUN = 15;
    localparam int DLY_LEAD_LO = 8;
    localparam int DLY_POST_LO = 0;
    // Queue pointer register fields
    localparam int QP_HALT = 15;
    localparam int QP_WRAP = 14;
    localparam int QP_IDLE = 12;
    localparam int QP_LAST_LO = 8;
    localparam int QP_CUR_LO = 4;
    localparam int QP_FIRST_LO = 0;
    // Interrupt register flags
    localparam int IR_COLL = 3;
    localparam int IR_DONE = 0;
    // Reset values and transfer bit counts
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [3:0] CS_RESET = 4'hF;
    localparam logic [4:0] NARROW_BITS = 5'h08;
    localparam logic [4:0] FULL_BITS = 5'h10;
    typedef enum logic [1:0] {Q_IDLE, Q_ISSUE, Q_WAIT} qsce_seq_e;
    typedef enum logic [1:0] {E_IDLE, E_LEAD, E_SHIFT, E_POST} qsce_eng_e;
endpackage : qsce_pkg

// *** rtl/qsce_sync.sv ***
`timescale 1ns/1ns
module qsce_sync (
    input wire logic i_clk,
    input wire logic i_d,
    output logic o_q
);
    logic meta_reg;
    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        o_q <= meta_reg;
    end
endmodule : qsce_sync

// *** rtl/qsce_engine.sv ***
`timescale 1ns/1ns
module qsce_engine (
    input wire logic i_link_clk,
    input wire logic i_link_rst,
    input wire logic i_req_tog,
    input wire logic i_miso,
    input wire logic [7:0] i_cmd,
    input wire logic [15:0] i_tx,
    input wire logic [3:0] i_bits,
    input wire logic [7:0] i_baud,
    input wire logic [6:0] i_lead,
    input wire logic [7:0] i_dtl,
    input wire logic i_idle_lvl,
    output logic o_sck,
    output logic o_mosi,
    output logic [3:0] o_cs,
    output logic o_done_tog,
    output logic [15:0] o_rx
);
    typedef struct packed {
        qsce_pkg::qsce_eng_e st;
        logic req_seen;
        logic [7:0] cnt;
        logic [4:0] nbits;
        logic [15:0] sh;
        logic sck;
        logic mosi;
        logic [3:0] cs;
        logic done_t;
        logic [15:0] rx;
    } qsce_eng_s;
    qsce_eng_s eng_reg, eng_next;
    logic [4:0] width_sel;

    always_comb begin
        eng_next = eng_reg;
        eng_next.req_seen = i_req_tog;
        // R5: eight bits or mode width
        width_sel = i_cmd[6] ? ((i_bits == 4'h0) ? qsce_pkg::FULL_BITS : {1'b0, i_bits})
                             : qsce_pkg::NARROW_BITS;
        unique case (eng_reg.st)
            qsce_pkg::E_IDLE: begin
                if (i_req_tog != eng_reg.req_seen) begin
                    // R8: selects straight from entry
                    eng_next.cs = i_cmd[3:0];
                    eng_next.nbits = width_sel;
                    eng_next.sh = i_tx << (5'd16 - width_sel);
                    eng_next.mosi = eng_next.sh[15];
                    eng_next.rx = 16'h0000;
                    // R7: lead delay or half period
                    eng_next.cnt = i_cmd[4] ? {1'b0, i_lead} : i_baud;
                    eng_next.st = qsce_pkg::E_LEAD;
                end
            end
            qsce_pkg::E_LEAD: begin
                if (eng_reg.cnt > 8'h01) begin
                    eng_next.cnt = eng_reg.cnt - 8'h01;
                end else begin
                    eng_next.cnt = i_baud;
                    eng_next.st = qsce_pkg::E_SHIFT;
                end
            end
            qsce_pkg::E_SHIFT: begin
                if (eng_reg.cnt > 8'h01) begin
                    eng_next.cnt = eng_reg.cnt - 8'h01;
                end else if (!eng_reg.sck) begin
                    eng_next.cnt = i_baud;
                    eng_next.sck = 1'b1;
                    // Half period under three link clocks reads a stale bit
                    eng_next.rx = {eng_reg.rx[14:0], i_miso};
                end else begin
                    eng_next.cnt = i_baud;
                    eng_next.sck = 1'b0;
                    eng_next.sh = {eng_reg.sh[14:0], 1'b0};
                    eng_next.mosi = eng_reg.sh[14];
                    eng_next.nbits = eng_reg.nbits - 5'h01;
                    if (eng_reg.nbits == 5'h01) begin
                        // R6: optional post-transfer delay
                        eng_next.cnt = i_cmd[5] ? i_dtl : 8'h00;
                        eng_next.st = qsce_pkg::E_POST;
                    end
                end
            end
            qsce_pkg::E_POST: begin
                if (eng_reg.cnt > 8'h01) begin
                    eng_next.cnt = eng_reg.cnt - 8'h01;
                end else begin
                    // R4: hold selects or return idle
                    if (!i_cmd[7]) begin
                        eng_next.cs = {4{i_idle_lvl}};
                    end
                    eng_next.done_t = ~eng_reg.done_t;
                    eng_next.st = qsce_pkg::E_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            eng_reg <= '{st: qsce_pkg::E_IDLE, req_seen: 1'b0, cnt: 8'h00, nbits: 5'h00,
                         sh: 16'h0000, sck: 1'b0, mosi: 1'b0, cs: qsce_pkg::CS_RESET,
                         done_t: 1'b0, rx: 16'h0000};
        end else begin
            eng_reg <= eng_next;
        end
    end

    assign o_sck = eng_reg.sck;
    assign o_mosi = eng_reg.mosi;
    assign o_cs = eng_reg.cs;
    assign o_done_tog = eng_reg.done_t;
    assign o_rx = eng_reg.rx;

    a_cs_from_entry: assert property (@(posedge i_link_clk) disable iff (i_link_rst) // R8
        eng_reg.st == qsce_pkg::E_SHIFT |-> o_cs == i_cmd[3:0])
        else $error("select outputs differ from entry");
    a_width_narrow: assert property (@(posedge i_link_clk) disable iff (i_link_rst) // R5
        (eng_reg.st == qsce_pkg::E_IDLE && i_req_tog != eng_reg.req_seen && !i_cmd[6])
        |=> eng_reg.nbits == 5'h08)
        else $error("narrow transfer not eight bits");
    a_cs_release: assert property (@(posedge i_link_clk) disable iff (i_link_rst) // R4
        ($changed(eng_reg.done_t) && !i_cmd[7]) |-> o_cs == {4{i_idle_lvl}})
        else $error("selects not back at idle level");
    c_held_selects: cover property (@(posedge i_link_clk) disable iff (i_link_rst)
        $changed(eng_reg.done_t) && i_cmd[7]);
endmodule : qsce_engine

// *** rtl/qsce_top.sv ***
// Overview of operation
// R1: Sixteen byte entries: selects plus command
// R2: Entries reached via data port top byte
// R3: Serial engine never modifies command entries
// R4: Bit 15 holds selects, else idle level
// R5: Bit 14 picks eight or mode width
// R6: Bit 13 adds post-transfer delay
// R7: Bit 12 picks lead delay or half-period
// R8: Bits 11..8 drive selects 3..0 directly
// R9: Software sets idle level to hold selects
// R10: Pointer 0x20 commands, 0x00 tx, 0x10 rx
// R11: Queue pointer 0x0F00 means entries 0..15
// R12: Load, set pointers, run, await done
// R13: Done flag at last entry or halt
// R14: Data port access bumps pointer; read waits
// R15: Collision flag on executing-entry write, W1C
// R16: Entries run ascending first to last
`timescale 1ns/1ns
module qsce_top (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_LINK_CLK,
    input wire logic [2:0] I_REG_SEL,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [15:0] I_WDATA,
    input wire logic I_MISO,
    output logic [15:0] O_RDATA,
    output logic O_RVALID,
    output logic O_SCK,
    output logic O_MOSI,
    output logic [3:0] O_CS
);
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] delay;
        logic halt;
        logic wrap;
        logic idle_lvl;
        logic [3:0] last_p;
        logic [3:0] first_p;
        logic [3:0] cur_p;
        logic done_f;
        logic coll_f;
        logic [5:0] ptr;
        logic [15:0][7:0] cmd;
        logic [15:0][15:0] tx;
        logic [15:0][15:0] rx;
        qsce_pkg::qsce_seq_e st;
        logic req_t;
        logic done_seen;
        logic [7:0] x_cmd;
        logic [15:0] x_tx;
        logic [3:0] x_bits;
        logic [7:0] x_baud;
        logic [6:0] x_lead;
        logic [7:0] x_dtl;
        logic x_idle;
        logic rd_pend;
        logic [2:0] rd_sel;
        logic [15:0] rdata;
        logic rvalid;
    } qsce_top_s;
    qsce_top_s top_reg, top_next;

    logic link_rst;
    logic req_link;
    logic miso_link;
    logic done_sys;
    logic done_tog;
    logic [15:0] rx_word;
    logic wr_data;
    logic done_edge;
    logic busy;
    logic running;

    // R10: pointer section decode
    // Section decode: 0 tx, 1 rx, 2 command, 3 unmapped
    function automatic logic [1:0] ptr_section(input logic [5:0] p);
        if (p[5:4] == qsce_pkg::BASE_CMD[5:4]) begin
            ptr_section = 2'h2;
        end else if (p[5:4] == qsce_pkg::BASE_RX[5:4]) begin
            ptr_section = 2'h1;
        end else if (p[5:4] == qsce_pkg::BASE_TX[5:4]) begin
            ptr_section = 2'h0;
        end else begin
            ptr_section = 2'h3;
        end
    endfunction : ptr_section

    qsce_sync u_rst_sync (.i_clk(I_LINK_CLK), .i_d(I_RST), .o_q(link_rst));
    qsce_sync u_req_sync (.i_clk(I_LINK_CLK), .i_d(top_reg.req_t), .o_q(req_link));
    qsce_sync u_miso_sync (.i_clk(I_LINK_CLK), .i_d(I_MISO), .o_q(miso_link));
    qsce_sync u_done_sync (.i_clk(I_CLK), .i_d(done_tog), .o_q(done_sys));

    // Payload is held still by the sequencer from request toggle until done toggle
    qsce_engine u_engine (
        .i_link_clk(I_LINK_CLK),
        .i_link_rst(link_rst),
        .i_req_tog(req_link),
        .i_miso(miso_link),
        .i_cmd(top_reg.x_cmd),
        .i_tx(top_reg.x_tx),
        .i_bits(top_reg.x_bits),
        .i_baud(top_reg.x_baud),
        .i_lead(top_reg.x_lead),
        .i_dtl(top_reg.x_dtl),
        .i_idle_lvl(top_reg.x_idle),
        .o_sck(O_SCK),
        .o_mosi(O_MOSI),
        .o_cs(O_CS),
        .o_done_tog(done_tog),
        .o_rx(rx_word)
    );

    assign wr_data = I_WR && (I_REG_SEL == qsce_pkg::SEL_DATA);
    assign done_edge = done_sys != top_reg.done_seen;
    assign busy = top_reg.st != qsce_pkg::Q_IDLE;
    assign running = top_reg.delay[qsce_pkg::DLY_RUN];

    always_comb begin
        top_next = top_reg;
        top_next.rvalid = 1'b0;
        top_next.rd_pend = I_RD;
        top_next.rd_sel = I_REG_SEL;
        top_next.done_seen = done_sys;
        if (I_WR) begin
            unique case (I_REG_SEL)
                qsce_pkg::SEL_MODE: top_next.mode = I_WDATA;
                qsce_pkg::SEL_DELAY: top_next.delay = I_WDATA;
                qsce_pkg::SEL_QPTR: begin
                    // R11: last and first entry pointers
                    top_next.halt = I_WDATA[qsce_pkg::QP_HALT];
                    top_next.wrap = I_WDATA[qsce_pkg::QP_WRAP];
                    top_next.idle_lvl = I_WDATA[qsce_pkg::QP_IDLE];
                    top_next.last_p = I_WDATA[qsce_pkg::QP_LAST_LO +: 4];
                    top_next.first_p = I_WDATA[qsce_pkg::QP_FIRST_LO +: 4];
                end
                qsce_pkg::SEL_INTR: begin
                    // R15: write one clears
                    if (I_WDATA[qsce_pkg::IR_COLL]) begin
                        top_next.coll_f = 1'b0;
                    end
                    if (I_WDATA[qsce_pkg::IR_DONE]) begin
                        top_next.done_f = 1'b0;
                    end
                end
                qsce_pkg::SEL_IPTR: top_next.ptr = I_WDATA[qsce_pkg::PTR_W-1:0];
                qsce_pkg::SEL_DATA: begin
                    // R14: write then bump pointer
                    top_next.ptr = top_reg.ptr + 6'h01;
                    unique case (ptr_section(top_reg.ptr))
                        2'h0: top_next.tx[top_reg.ptr[3:0]] = I_WDATA;
                        2'h1: top_next.rx[top_reg.ptr[3:0]] = I_WDATA;
                        2'h2: begin
                            // R15: executing entry write is refused
                            if (busy && top_reg.ptr[3:0] == top_reg.cur_p) begin
                                top_next.coll_f = 1'b1;
                            end else begin
                                // R2: top byte of data port
                                top_next.cmd[top_reg.ptr[3:0]] = I_WDATA[15:8];
                            end
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        // R14: read answered after one wait state
        if (top_reg.rd_pend) begin
            top_next.rvalid = 1'b1;
            unique case (top_reg.rd_sel)
                qsce_pkg::SEL_MODE: top_next.rdata = top_reg.mode;
                qsce_pkg::SEL_DELAY: top_next.rdata = top_reg.delay;
                qsce_pkg::SEL_QPTR: begin
                    top_next.rdata = 16'h0000;
                    top_next.rdata[qsce_pkg::QP_HALT] = top_reg.halt;
                    top_next.rdata[qsce_pkg::QP_WRAP] = top_reg.wrap;
                    top_next.rdata[qsce_pkg::QP_IDLE] = top_reg.idle_lvl;
                    top_next.rdata[qsce_pkg::QP_LAST_LO +: 4] = top_reg.last_p;
                    top_next.rdata[qsce_pkg::QP_CUR_LO +: 4] = top_reg.cur_p;
                    top_next.rdata[qsce_pkg::QP_FIRST_LO +: 4] = top_reg.first_p;
                end
                qsce_pkg::SEL_INTR: begin
                    top_next.rdata = 16'h0000;
                    top_next.rdata[qsce_pkg::IR_COLL] = top_reg.coll_f;
                    top_next.rdata[qsce_pkg::IR_DONE] = top_reg.done_f;
                end
                qsce_pkg::SEL_IPTR: top_next.rdata = {10'h000, top_reg.ptr};
                qsce_pkg::SEL_DATA: begin
                    top_next.ptr = top_reg.ptr + 6'h01;
                    unique case (ptr_section(top_reg.ptr))
                        2'h0: top_next.rdata = top_reg.tx[top_reg.ptr[3:0]];
                        2'h1: top_next.rdata = top_reg.rx[top_reg.ptr[3:0]];
                        2'h2: top_next.rdata = {top_reg.cmd[top_reg.ptr[3:0]], 8'h00};
                        default: top_next.rdata = 16'h0000;
                    endcase
                end
                default: top_next.rdata = 16'h0000;
            endcase
        end
        // Sequencer after host writes so hardware sets win over clears
        unique case (top_reg.st)
            qsce_pkg::Q_IDLE: begin
                // R12: run bit starts the queue
                if (running) begin
                    top_next.cur_p = top_reg.first_p;
                    top_next.st = qsce_pkg::Q_ISSUE;
                end
            end
            qsce_pkg::Q_ISSUE: begin
                // R1: entry fields steer this transfer
                top_next.x_cmd = top_reg.cmd[top_reg.cur_p];
                top_next.x_tx = top_reg.tx[top_reg.cur_p];
                top_next.x_bits = top_reg.mode[qsce_pkg::MODE_BITS_LO +: 4];
                top_next.x_baud = top_reg.mode[qsce_pkg::MODE_BAUD_LO +: 8];
                top_next.x_lead = top_reg.delay[qsce_pkg::DLY_LEAD_LO +: 7];
                top_next.x_dtl = top_reg.delay[qsce_pkg::DLY_POST_LO +: 8];
                top_next.x_idle = top_reg.idle_lvl;
                top_next.req_t = ~top_reg.req_t;
                top_next.st = qsce_pkg::Q_WAIT;
            end
            qsce_pkg::Q_WAIT: begin
                if (done_edge) begin
                    top_next.rx[top_reg.cur_p] = rx_word;
                    // R13: done at last entry or halt
                    if (top_reg.cur_p == top_reg.last_p || top_reg.halt || !running) begin
                        top_next.done_f = 1'b1;
                        if (top_reg.wrap && !top_reg.halt && running) begin
                            top_next.cur_p = top_reg.first_p;
                            top_next.st = qsce_pkg::Q_ISSUE;
                        end else begin
                            top_next.delay[qsce_pkg::DLY_RUN] = 1'b0;
                            top_next.st = qsce_pkg::Q_IDLE;
                        end
                    end else begin
                        // R16: next entry in ascending order
                        top_next.cur_p = top_reg.cur_p + 4'h1;
                        top_next.st = qsce_pkg::Q_ISSUE;
                    end
                end
            end
            default: top_next.st = qsce_pkg::Q_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            top_reg <= '0;
            top_reg.mode <= qsce_pkg::MODE_RESET;
            top_reg.delay <= qsce_pkg::DELAY_RESET;
            top_reg.st <= qsce_pkg::Q_IDLE;
        end else begin
            top_reg <= top_next;
        end
    end

    assign O_RDATA = top_reg.rdata;
    assign O_RVALID = top_reg.rvalid;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    a_read_wait: assert property (I_RD |=> ##1 O_RVALID) // R14
        else $error("read not answered after one wait state");
    a_no_stray_valid: assert property (!I_RD |=> ##1 !O_RVALID) // R14
        else $error("read answer without request");
    a_ptr_bump: assert property (wr_data && !I_RD && !top_reg.rd_pend // R14
        |=> top_reg.ptr == $past(top_reg.ptr) + 6'h01)
        else $error("pointer did not advance on data write");
    a_cmd_fixed: assert property (!(wr_data && top_reg.ptr[5:4] == 2'h2) // R3
        |=> top_reg.cmd == $past(top_reg.cmd))
        else $error("command entries changed without host write");
    a_coll_set: assert property ((wr_data && busy && top_reg.ptr[5:4] == 2'h2 // R15
        && top_reg.ptr[3:0] == top_reg.cur_p) |=> top_reg.coll_f)
        else $error("collision flag not set");
    a_done_last: assert property ((top_reg.st == qsce_pkg::Q_WAIT && done_edge // R13
        && top_reg.cur_p == top_reg.last_p) |=> top_reg.done_f)
        else $error("done flag missing at last entry");
    a_start_first: assert property ((top_reg.st == qsce_pkg::Q_IDLE && running) // R16
        |=> top_reg.cur_p == top_reg.first_p ##1 top_reg.st == qsce_pkg::Q_WAIT)
        else $error("queue did not start at first entry");
    a_step_up: assert property ((top_reg.st == qsce_pkg::Q_WAIT && done_edge && running // R16
        && !top_reg.halt && top_reg.cur_p != top_reg.last_p)
        |=> top_reg.cur_p == $past(top_reg.cur_p) + 4'h1)
        else $error("entry order not ascending");
    c_done: cover property ($rose(top_reg.done_f));
    c_collision: cover property ($rose(top_reg.coll_f));
    c_wrap_pass: cover property (top_reg.wrap && $rose(top_reg.done_f) ##1 running);
endmodule : qsce_top

// *** tb/qsce_periph.sv ***
`timescale 1ns/1ns
module qsce_periph (
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic [3:0] i_cs,
    output logic o_miso,
    output logic [31:0] o_got,
    output logic [7:0] o_rises
);
    logic [31:0] reply_reg = 32'hC35A_9600;
    logic last_reg = 1'b0;
    initial o_got = 32'h0000_0000;
    initial o_rises = 8'h00;
    // Released line inverts, so a stale bit cannot pass
    assign o_miso = (i_cs != 4'hF) ? reply_reg[31] : ~last_reg;
    always @(posedge i_sck) begin
        o_got <= {o_got[30:0], i_mosi};
        o_rises <= o_rises + 8'h01;
    end
    // Next bit presented after each falling edge
    always @(negedge i_sck) begin
        last_reg <= reply_reg[31];
        reply_reg <= {reply_reg[30:0], 1'b0};
    end
endmodule : qsce_periph

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic I_CLK = 1'b0;
    logic I_LINK_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic [2:0] I_REG_SEL = 3'h0;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic [15:0] I_WDATA = 16'h0000;
    logic I_MISO;
    logic [15:0] O_RDATA;
    logic O_RVALID;
    logic O_SCK;
    logic O_MOSI;
    logic [3:0] O_CS;
    logic [31:0] got;
    logic [7:0] rises;
    logic [15:0] rdv;
    int n_errors = 0;
    int num_checks = 0;

    initial begin
        forever #10 I_CLK = ~I_CLK;
    end
    // Odd offset keeps the link clock unrelated in phase
    initial begin
        #3;
        forever #6 I_LINK_CLK = ~I_LINK_CLK;
    end

    qsce_top dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_LINK_CLK(I_LINK_CLK),
        .I_REG_SEL(I_REG_SEL), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA),
        .I_MISO(I_MISO), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_SCK(O_SCK),
        .O_MOSI(O_MOSI), .O_CS(O_CS));
    qsce_periph partner (.i_sck(O_SCK), .i_mosi(O_MOSI), .i_cs(O_CS),
        .o_miso(I_MISO), .o_got(got), .o_rises(rises));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] sel, input logic [15:0] data);
        @(negedge I_CLK);
        I_REG_SEL = sel;
        I_WDATA = data;
        I_WR = 1'b1;
        @(negedge I_CLK);
        I_WR = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] sel, output logic [15:0] data);
        @(negedge I_CLK);
        I_REG_SEL = sel;
        I_RD = 1'b1;
        @(negedge I_CLK);
        I_RD = 1'b0;
        @(negedge I_CLK);
        check(O_RVALID, 1);
        data = O_RDATA;
    endtask : rd

    task automatic t_reset();
        check({O_CS, O_SCK, O_RVALID}, 6'h3C);
    endtask : t_reset

    task automatic t_entries();
        wr(qsce_pkg::SEL_IPTR, 16'h0020);
        for (int i = 0; i < qsce_pkg::ENTRIES; i++) begin
            wr(qsce_pkg::SEL_DATA, {8'(i) * 8'h11, 8'hFF});
        end
        wr(qsce_pkg::SEL_IPTR, 16'h0020);
        for (int i = 0; i < qsce_pkg::ENTRIES; i++) begin
            rd(qsce_pkg::SEL_DATA, rdv);
            check(rdv, {8'(i) * 8'h11, 8'h00});
        end
        // Pointer runs past the section into unmapped space
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h0000);
    endtask : t_entries

    task automatic t_sections();
        wr(qsce_pkg::SEL_IPTR, 16'h0010);
        wr(qsce_pkg::SEL_DATA, 16'h1234);
        wr(qsce_pkg::SEL_IPTR, 16'h0000);
        wr(qsce_pkg::SEL_DATA, 16'h00A5);
        wr(qsce_pkg::SEL_DATA, 16'h0ABC);
        wr(qsce_pkg::SEL_IPTR, 16'h0020);
        wr(qsce_pkg::SEL_DATA, 16'h0E00);
        wr(qsce_pkg::SEL_DATA, 16'hFD00);
        wr(qsce_pkg::SEL_IPTR, 16'h0000);
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h00A5);
        wr(qsce_pkg::SEL_IPTR, 16'h0010);
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h1234);
    endtask : t_sections

    task automatic t_queue();
        // Half period of four outlasts the receive synchroniser
        wr(qsce_pkg::SEL_MODE, 16'h3004);
        wr(qsce_pkg::SEL_DELAY, 16'h0304);
        wr(qsce_pkg::SEL_QPTR, 16'h1100);
        wr(qsce_pkg::SEL_INTR, 16'h0009);
        wr(qsce_pkg::SEL_DELAY, 16'h8304);
        @(posedge O_SCK);
        #1;
        check(O_CS, 4'hE);
        // Write to the entry now running
        wr(qsce_pkg::SEL_IPTR, 16'h0020);
        wr(qsce_pkg::SEL_DATA, 16'h5500);
        for (int k = 0; k < 400 && O_CS !== 4'hF; k++) @(negedge I_CLK);
        check(O_CS, 4'hF);
        check(rises, 8'h08);
        @(posedge O_SCK);
        #1;
        check(O_CS, 4'hD);
        rdv = 16'h0000;
        for (int k = 0; k < 200 && rdv[0] !== 1'b1; k++) rd(qsce_pkg::SEL_INTR, rdv);
        check(rdv, 16'h0009);
        check(rises, 8'h14);
        check({12'h000, got[19:0]}, 32'h000A_5ABC);
        check(O_CS, 4'hD);
        rd(qsce_pkg::SEL_DELAY, rdv);
        check(rdv, 16'h0304);
        wr(qsce_pkg::SEL_IPTR, 16'h0020);
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h0E00);
        wr(qsce_pkg::SEL_IPTR, 16'h0010);
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h00C3);
        rd(qsce_pkg::SEL_DATA, rdv);
        check(rdv, 16'h05A9);
    endtask : t_queue

    task automatic t_flags();
        wr(qsce_pkg::SEL_INTR, 16'h0000);
        rd(qsce_pkg::SEL_INTR, rdv);
        check(rdv, 16'h0009);
        wr(qsce_pkg::SEL_INTR, 16'h0009);
        rd(qsce_pkg::SEL_INTR, rdv);
        check(rdv, 16'h0000);
        // Current field still shows the last entry run
        wr(qsce_pkg::SEL_QPTR, 16'h0F00);
        rd(qsce_pkg::SEL_QPTR, rdv);
        check(rdv, 16'h0F10);
    endtask : t_flags

    task automatic t_wrap();
        // Entry 0 alone in wraparound, stopped by clearing run
        wr(qsce_pkg::SEL_QPTR, 16'h5000);
        wr(qsce_pkg::SEL_DELAY, 16'h8304);
        for (int pass = 0; pass < 2; pass++) begin
            rdv = 16'h0000;
            for (int k = 0; k < 200 && rdv[0] !== 1'b1; k++) rd(qsce_pkg::SEL_INTR, rdv);
            check(rdv, 16'h0001);
            wr(qsce_pkg::SEL_INTR, 16'h0001);
        end
        rd(qsce_pkg::SEL_DELAY, rdv);
        check(rdv, 16'h8304);
        wr(qsce_pkg::SEL_DELAY, 16'h0304);
        repeat (100) @(negedge I_CLK);
        rdv = {8'h00, rises};
        repeat (100) @(negedge I_CLK);
        check({8'h00, rises}, rdv);
        check(O_CS, 4'hF);
    endtask : t_wrap

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // Whole run needs about twelve microseconds
    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge I_CLK);
        I_RST = 1'b0;
        t_reset();
        t_entries();
        t_sections();
        t_queue();
        t_flags();
        t_wrap();
        final_report();
    end
endmodule : testbench
